/* testbench/flash_dev_model.sv */
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model
#(
	parameter int BUSY_CYC = 300,
	parameter logic [7:0] ID_CODE = 8'h3C // arbitrary value
)
(
	// timing clock
	input wire logic	ref_clk,
	// flash pins
	input wire logic	chip_sel_n,
	input wire logic	out_gate_n,
	input wire logic	write_strobe_n,
	input wire logic [16:0]	flash_addr,
	input wire logic [7:0]	data_lines_o,
	output logic [7:0]	data_lines_i
);
	logic [7:0]	mem [int];
	logic [16:0]	lat_addr;
	logic [7:0]	set_cmd, pgm_data, val = 8'h00, last = 8'h00;
	int		step = 0, busy = 0;
	bit		ers = 0, tog = 0, id_mode = 0;
	logic [1:0]	lock = 2'b00;
	wire		rd_on = !chip_sel_n && !out_gate_n;
	function automatic logic [7:0] rd(logic [16:0] a);
		return mem.exists(a) ? mem[a] : 8'hFF;
	endfunction : rd
	function automatic bit locked(logic [16:0] a);
		return (lock[1] && a >= 17'h1C000) || (lock[0] && a < 17'h04000);
	endfunction : locked
	task automatic wr(logic [16:0] a, logic [7:0] d);
		bit ok;
		if (busy > 0) return;
		if (step == 0 && d == 8'hF0) id_mode = 0;
		if (step == 3 && set_cmd == 8'hA0)
		begin
			step = 0;
			if (locked(a)) return;
			pgm_data = d;
			mem[a] = rd(a) & d;
			ers = 0;
			busy = BUSY_CYC;
			return;
		end
		if (step == 2) set_cmd = d;
		case (step)
			0, 3: ok = a[14:0] == 15'h5555 && d == 8'hAA;
			1, 4: ok = a[14:0] == 15'h2AAA && d == 8'h55;
			2: ok = a[14:0] == 15'h5555 && d inside {8'h80, 8'hA0, 8'h90, 8'hF0};
			5: ok = d == 8'h50 || (a[14:0] == 15'h5555 && d inside {8'h10, 8'h70});
			default: ok = a == 17'h1FFFF || a == 17'h00000;
		endcase
		step = ok ? step + 1 : 0;
		if (step == 3 && set_cmd inside {8'h90, 8'hF0})
		begin
			id_mode = set_cmd == 8'h90;
			step = 0;
		end
		if (step == 6 && d != 8'h70)
		begin
			step = 0;
			ers = 1;
			busy = BUSY_CYC;
			foreach (mem[k]) if (!locked(17'(k)) && (d == 8'h10 || k[16:12] == a[16:12])) mem[k] = 8'hFF;
		end
		if (step == 7)
		begin
			step = 0;
			lock[a[16]] = 1'b1;
		end
	endtask : wr
	always @(negedge write_strobe_n) if (!chip_sel_n && out_gate_n) lat_addr = flash_addr;
	always @(posedge write_strobe_n) if (!chip_sel_n && out_gate_n) wr(lat_addr, data_lines_o);
	always @(posedge ref_clk) if (busy > 0) busy--;
	always @(posedge rd_on) if (busy > 0) tog = ~tog;
	// status while busy, id or array otherwise
	always @(posedge ref_clk)
	begin
		val <= busy > 0 ? {ers ? 1'b0 : ~pgm_data[7], tog, 6'h2A} : id_mode ? ID_CODE : rd(flash_addr);
		if (rd_on) last <= val;
	end
	// released bus shows the inverse of the last value
	assign data_lines_i = rd_on ? val : ~last;
endmodule : flash_dev_model
`default_nettype wire

/* testbench/flash_erase_and_status_sequencer_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module flash_erase_and_status_sequencer_tb;
	localparam logic [7:0] ID_CODE = 8'h3C; // arbitrary value
	logic		ref_clk = 0, rst = 1, op_valid = 0, op_ready, op_done, op_error, er;
	logic [2:0]	op_code = 3'h0;
	logic [16:0]	op_addr = 17'h00000, flash_addr;
	logic [7:0]	op_data = 8'h00, op_rdata, rd, data_lines_o, data_lines_i;
	logic		chip_sel_n, out_gate_n, write_strobe_n, data_lines_oe_n;
	int		n_fail = 0, total_checks = 0;
	always #2.5 ref_clk = ~ref_clk;
	flash_erase_and_status_sequencer #(.POLL_LIMIT(16)) i_dut (.ref_clk(ref_clk), .rst(rst),
		.op_valid(op_valid), .op_ready(op_ready), .op_code(op_code), .op_addr(op_addr),
		.op_data(op_data), .op_done(op_done), .op_error(op_error), .op_rdata(op_rdata),
		.chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n), .write_strobe_n(write_strobe_n),
		.flash_addr(flash_addr), .data_lines_o(data_lines_o), .data_lines_oe_n(data_lines_oe_n),
		.data_lines_i(data_lines_i));
	flash_dev_model #(.BUSY_CYC(300), .ID_CODE(ID_CODE)) i_flash (.ref_clk(ref_clk),
		.chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n), .write_strobe_n(write_strobe_n),
		.flash_addr(flash_addr), .data_lines_o(data_lines_o), .data_lines_i(data_lines_i));
	////////////////////////////////////////////////////////////
	task automatic chk(string s, logic [7:0] e, logic [7:0] g);
		total_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic run(logic [2:0] c, logic [16:0] a, logic [7:0] d);
		int n;
		@(negedge ref_clk);
		op_code = c;
		op_addr = a;
		op_data = d;
		op_valid = 1'b1;
		for (n = 0; op_ready !== 1'b1 && n < 100; n++) @(negedge ref_clk);
		@(negedge ref_clk);
		op_valid = 1'b0;
		for (n = 0; op_done !== 1'b1 && n < 8000; n++) @(negedge ref_clk);
		chk("op_done", 8'h01, {7'h00, op_done});
		rd = op_rdata;
		er = op_error;
	endtask : run
	task automatic read_chk(string s, logic [16:0] a, logic [7:0] e);
		run(3'h0, a, 8'h00);
		chk(s, e, rd);
	endtask : read_chk
	task automatic t_program;
		run(3'h1, 17'h00012, 8'h5A);
		chk("prog_poll", 8'h5A, rd);
		chk("prog_err", 8'h00, {7'h00, er});
		run(3'h1, 17'h00012, 8'h0F);
		chk("prog_and", 8'h0A, rd);
		read_chk("prog_read", 17'h00012, 8'h0A);
	endtask : t_program
	task automatic t_page;
		run(3'h1, 17'h01005, 8'h00);
		run(3'h1, 17'h02005, 8'h00);
		run(3'h3, 17'h01ABC, 8'h00);
		chk("page_poll", 8'hFF, rd);
		read_chk("page_in", 17'h01005, 8'hFF);
		read_chk("page_out", 17'h02005, 8'h00);
	endtask : t_page
	task automatic t_chip;
		run(3'h2, 17'h02005, 8'h00);
		chk("chip_poll", 8'hFF, rd);
		read_chk("chip_read", 17'h00012, 8'hFF);
	endtask : t_chip
	task automatic t_ident;
		run(3'h6, 17'h00000, 8'h00);
		read_chk("id_read", 17'h00000, ID_CODE);
		run(3'h7, 17'h00000, 8'h00);
		read_chk("id_exit", 17'h00000, 8'hFF);
	endtask : t_ident
	task automatic t_lock;
		run(3'h4, 17'h00000, 8'h00);
		run(3'h1, 17'h1FFF0, 8'h00);
		chk("top_err", 8'h01, {7'h00, er});
		read_chk("top_keep", 17'h1FFF0, 8'hFF);
		run(3'h1, 17'h1BFF0, 8'h00);
		chk("below_top", 8'h00, {7'h00, er});
		run(3'h5, 17'h00000, 8'h00);
		run(3'h1, 17'h03FFF, 8'h00);
		chk("bot_err", 8'h01, {7'h00, er});
		read_chk("bot_keep", 17'h03FFF, 8'hFF);
	endtask : t_lock
	task automatic t_reset;
		@(negedge ref_clk);
		rst = 1'b1;
		repeat (2) @(negedge ref_clk);
		rst = 1'b0;
		@(negedge ref_clk);
		chk("rst_ready", 8'h01, {7'h00, op_ready});
		chk("rst_pins", 8'h0F, {4'h0, chip_sel_n, out_gate_n, write_strobe_n, data_lines_oe_n});
		read_chk("rst_read", 17'h00012, 8'hFF);
	endtask : t_reset
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results
	initial
	begin
		repeat (12) @(negedge ref_clk);
		rst = 1'b0;
		t_program();
		t_page();
		t_chip();
		t_ident();
		t_lock();
		t_reset();
		results();
	end
	initial
	begin
		#400000;
		n_fail++;
		results();
	end
endmodule : flash_erase_and_status_sequencer_tb
`default_nettype wire

/* testbench/flash_seq_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module flash_seq_sva
#(
	parameter int POLL_LIMIT = 65535
)
(
	// clock and reset
	input wire logic	ref_clk,
	input wire logic	rst,
	// user command port
	input wire logic	op_valid,
	input wire logic	op_ready,
	input wire logic [2:0]	op_code,
	input wire logic [16:0]	op_addr,
	input wire logic [7:0]	op_data,
	input wire logic	op_done,
	input wire logic	op_error,
	input wire logic [7:0]	op_rdata,
	// flash pins
	input wire logic	chip_sel_n,
	input wire logic	out_gate_n,
	input wire logic	write_strobe_n,
	input wire logic [16:0]	flash_addr,
	input wire logic [7:0]	data_lines_o,
	input wire logic	data_lines_oe_n,
	input wire logic [7:0]	data_lines_i
);
	logic [16:0]	a_reg;
	logic [7:0]	d_reg;
	wire		take = op_valid && op_ready;
	wire		wr = !write_strobe_n;
	always_ff @(posedge ref_clk) if (take) a_reg <= op_addr;
	always_ff @(posedge ref_clk) if (take) d_reg <= op_data;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////
	chk_write_gate: assert property (wr |-> !chip_sel_n && out_gate_n && !data_lines_oe_n)
		else $error("strobe outside a write cycle");
	chk_read_gate: assert property (!out_gate_n |-> !chip_sel_n && !wr && data_lines_oe_n)
		else $error("gate low during a write or with bus driven");
	chk_addr_hold: assert property (wr && !$past(write_strobe_n) |-> $stable(flash_addr) && $stable(data_lines_o))
		else $error("address or data moved under strobe");
	chk_unlock_first: assert property (take && op_code inside {[3'h1:3'h6]} |->
		##[1:60] (wr && flash_addr[14:0] == 15'h5555 && data_lines_o == 8'hAA))
		else $error("first unlock write missing");
	chk_id_exit: assert property (take && op_code == 3'h7 |-> ##[1:60] (wr && data_lines_o == 8'hF0))
		else $error("exit write missing");
	chk_program_tgt: assert property (take && op_code == 3'h1 |->
		##[1:300] (wr && flash_addr == a_reg && data_lines_o == d_reg))
		else $error("program write missing");
	chk_chip_cmd: assert property (take && op_code == 3'h2 |->
		##[1:400] (wr && flash_addr[14:0] == 15'h5555 && data_lines_o == 8'h10))
		else $error("chip erase write missing");
	chk_page_cmd: assert property (take && op_code == 3'h3 |->
		##[1:400] (wr && flash_addr[16:12] == a_reg[16:12] && data_lines_o == 8'h50))
		else $error("page erase write missing");
	chk_lock_top: assert property (take && op_code == 3'h4 |-> ##[1:500] (wr && flash_addr == 17'h1FFFF))
		else $error("top lock write missing");
	cover property (take && op_code == 3'h3);
	cover property (op_done && op_error);
	cover property (take && op_code == 3'h7);
endmodule : flash_seq_sva
bind flash_erase_and_status_sequencer flash_seq_sva #(.POLL_LIMIT(POLL_LIMIT)) i_sva (
	.ref_clk(ref_clk), .rst(rst), .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code),
	.op_addr(op_addr), .op_data(op_data), .op_done(op_done), .op_error(op_error),
	.op_rdata(op_rdata), .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n),
	.write_strobe_n(write_strobe_n), .flash_addr(flash_addr), .data_lines_o(data_lines_o),
	.data_lines_oe_n(data_lines_oe_n), .data_lines_i(data_lines_i));
`default_nettype wire

/* verilog/bus_cycle_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface bus_cycle_if;
	logic                                 start;
	logic                                 is_write;
	logic [flash_host_pkg::ADDR_W-1:0]    addr;
	logic [flash_host_pkg::DATA_W-1:0]    wdata;
	logic                                 done;
	logic [flash_host_pkg::DATA_W-1:0]    rdata;
	modport seq (output start, output is_write, output addr, output wdata,
		input done, input rdata);
	modport phy (input start, input is_write, input addr, input wdata,
		output done, output rdata);
endinterface : bus_cycle_if
`default_nettype wire

/* verilog/flash_bus_cycle.sv */
`timescale 1ns/100ps
`default_nettype none
module flash_bus_cycle
(
	// clock and reset
	input  wire logic                              ref_clk,
	input  wire logic                              rst,
	// sequencer side
	bus_cycle_if.phy                               cyc,
	// flash pins
	output logic                                   chip_sel_n,
	output logic                                   out_gate_n,
	output logic                                   write_strobe_n,
	output logic [flash_host_pkg::ADDR_W-1:0]      flash_addr,
	output logic [flash_host_pkg::DATA_W-1:0]      data_lines_o,
	output logic                                   data_lines_oe_n,
	input  wire logic [flash_host_pkg::DATA_W-1:0] data_lines_i
);
	typedef enum logic [2:0] {IDLE, W_SETUP, W_LOW, W_HIGH, R_LOW, R_GAP} phase_type;
	phase_type                         phase_reg;
	logic [flash_host_pkg::CNT_W-1:0]  cnt_reg;
	logic [flash_host_pkg::DATA_W-1:0] sync1_reg;
	logic [flash_host_pkg::DATA_W-1:0] sync2_reg;
	logic [flash_host_pkg::DATA_W-1:0] rdata_reg;
	logic                              done_reg;
	wire                               cnt_zero = (cnt_reg == '0);

	function automatic logic [flash_host_pkg::CNT_W-1:0] cyc_load(input int n);
		cyc_load = flash_host_pkg::CNT_W'(n - 1);
	endfunction : cyc_load

	assign cyc.done = done_reg;
	assign cyc.rdata = rdata_reg;

	always_ff @(posedge ref_clk)
	begin
		sync1_reg <= data_lines_i;
		sync2_reg <= sync1_reg;
	end

	////////////////////////////////////////////////////////////////////
	// write: address set, strobe low, strobe high; gate held high
	// read: select and gate fall together, each read is a new edge
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			phase_reg <= IDLE;
			cnt_reg <= '0;
			done_reg <= 1'b0;
			rdata_reg <= '0;
			chip_sel_n <= 1'b1;
			out_gate_n <= 1'b1;
			write_strobe_n <= 1'b1;
			flash_addr <= '0;
			data_lines_o <= '0;
			data_lines_oe_n <= 1'b1;
		end
		else
		begin
			done_reg <= 1'b0;
			if (!cnt_zero)
				cnt_reg <= cnt_reg - 1'b1;
			case (phase_reg)
				IDLE:
					if (cyc.start)
					begin
						flash_addr <= cyc.addr;
						if (cyc.is_write)
						begin
							data_lines_o <= cyc.wdata;
							data_lines_oe_n <= 1'b0;
							chip_sel_n <= 1'b0;
							cnt_reg <= cyc_load(flash_host_pkg::SETUP_CYC);
							phase_reg <= W_SETUP;
						end
						else
						begin
							chip_sel_n <= 1'b0;
							out_gate_n <= 1'b0;
							cnt_reg <= cyc_load(flash_host_pkg::READ_CYC + 2);
							phase_reg <= R_LOW;
						end
					end
				W_SETUP:
					if (cnt_zero)
					begin
						write_strobe_n <= 1'b0;
						cnt_reg <= cyc_load(flash_host_pkg::WE_LOW_CYC);
						phase_reg <= W_LOW;
					end
				W_LOW:
					if (cnt_zero)
					begin
						write_strobe_n <= 1'b1;
						cnt_reg <= cyc_load(flash_host_pkg::WE_HIGH_CYC);
						phase_reg <= W_HIGH;
					end
				W_HIGH:
					if (cnt_zero)
					begin
						chip_sel_n <= 1'b1;
						data_lines_oe_n <= 1'b1;
						done_reg <= 1'b1;
						phase_reg <= IDLE;
					end
				R_LOW:
					if (cnt_zero)
					begin
						rdata_reg <= sync2_reg;
						chip_sel_n <= 1'b1;
						out_gate_n <= 1'b1;
						cnt_reg <= cyc_load(flash_host_pkg::WE_HIGH_CYC);
						phase_reg <= R_GAP;
					end
				R_GAP:
					if (cnt_zero)
					begin
						done_reg <= 1'b1;
						phase_reg <= IDLE;
					end
				default:
					phase_reg <= IDLE;
			endcase
		end
	end
endmodule : flash_bus_cycle
`default_nettype wire

/* verilog/flash_erase_and_status_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none
module flash_erase_and_status_sequencer
#(
	parameter int POLL_LIMIT = 65535
)
(
	// clock and reset
	input  wire logic                              ref_clk,
	input  wire logic                              rst,
	// user command port
	input  wire logic                              op_valid,
	output logic                                   op_ready,
	input  wire logic [2:0]                        op_code,
	input  wire logic [flash_host_pkg::ADDR_W-1:0] op_addr,
	input  wire logic [flash_host_pkg::DATA_W-1:0] op_data,
	output logic                                   op_done,
	output logic                                   op_error,
	output logic [flash_host_pkg::DATA_W-1:0]      op_rdata,
	// flash pins
	output logic                                   chip_sel_n,
	output logic                                   out_gate_n,
	output logic                                   write_strobe_n,
	output logic [flash_host_pkg::ADDR_W-1:0]      flash_addr,
	output logic [flash_host_pkg::DATA_W-1:0]      data_lines_o,
	output logic                                   data_lines_oe_n,
	input  wire logic [flash_host_pkg::DATA_W-1:0] data_lines_i
);
	typedef enum logic [2:0] {S_IDLE, S_ISSUE, S_WAIT, S_POLL, S_POLL_WAIT,
		S_FINAL, S_FINAL_WAIT, S_DONE} state_type;

	bus_cycle_if cyc ();

	state_type                         state_reg;
	logic [2:0]                        code_reg;
	logic [flash_host_pkg::ADDR_W-1:0] addr_reg;
	logic [flash_host_pkg::DATA_W-1:0] data_reg;
	logic [2:0]                        step_reg;
	logic                              prev_tog_reg;
	logic                              first_poll_reg;
	logic [31:0]                       polls_reg;
	logic                              err_reg;
	logic [flash_host_pkg::DATA_W-1:0] rdata_reg;

	////////////////////////////////////////////////////////////////////
	// step table
	function automatic logic [2:0] step_count(input logic [2:0] c);
		case (c)
			flash_host_pkg::OP_PROGRAM:     step_count = 3'h4;
			flash_host_pkg::OP_CHIP_ERASE:  step_count = 3'h6;
			flash_host_pkg::OP_PAGE_ERASE:  step_count = 3'h6;
			flash_host_pkg::OP_LOCK_TOP:    step_count = 3'h7;
			flash_host_pkg::OP_LOCK_BOTTOM: step_count = 3'h7;
			flash_host_pkg::OP_ID_ENTRY:    step_count = 3'h3;
			flash_host_pkg::OP_ID_EXIT:     step_count = 3'h1;
			default:                        step_count = 3'h1;
		endcase
	endfunction : step_count

	// command address carries only bits 14..0, upper bits zero
	function automatic logic [16:0] cmd_addr(input logic [14:0] a);
		cmd_addr = {2'b00, a};
	endfunction : cmd_addr

	wire logic [2:0]  n_steps = step_count(code_reg);
	wire logic        is_erase = (code_reg == flash_host_pkg::OP_CHIP_ERASE) ||
		(code_reg == flash_host_pkg::OP_PAGE_ERASE);
	wire logic        needs_poll = is_erase || (code_reg == flash_host_pkg::OP_PROGRAM);
	wire logic        page_six = (code_reg == flash_host_pkg::OP_PAGE_ERASE);
	wire logic        lock_any = (code_reg == flash_host_pkg::OP_LOCK_TOP) ||
		(code_reg == flash_host_pkg::OP_LOCK_BOTTOM);
	wire logic        id_exit = (code_reg == flash_host_pkg::OP_ID_EXIT);
	wire logic [2:0]  last_step = 3'(n_steps - 3'h1);

	logic [16:0] step_addr;
	logic [7:0]  step_data;

	////////////////////////////////////////////////////////////////////
	// address/data of the current step
	always_comb
	begin
		step_addr = cmd_addr(flash_host_pkg::UNLOCK_ADDR_1);
		step_data = flash_host_pkg::UNLOCK_DATA_1;
		if (id_exit)
		begin
			step_addr = addr_reg;
			step_data = flash_host_pkg::CMD_ID_EXIT;
		end
		else
			case (step_reg)
				3'h1, 3'h4:
				begin
					step_addr = cmd_addr(flash_host_pkg::UNLOCK_ADDR_2);
					step_data = flash_host_pkg::UNLOCK_DATA_2;
				end
				3'h2:
					case (code_reg)
						flash_host_pkg::OP_PROGRAM:  step_data = flash_host_pkg::CMD_PROGRAM;
						flash_host_pkg::OP_ID_ENTRY: step_data = flash_host_pkg::CMD_ID_ENTRY;
						default:                     step_data = flash_host_pkg::CMD_SETUP;
					endcase
				3'h3:
					if (code_reg == flash_host_pkg::OP_PROGRAM)
					begin
						step_addr = addr_reg;
						step_data = data_reg;
					end
				3'h5:
					if (page_six)
					begin
						step_addr = addr_reg;
						step_data = flash_host_pkg::CMD_PAGE_ERASE;
					end
					else if (lock_any)
						step_data = flash_host_pkg::CMD_LOCKOUT;
					else
						step_data = flash_host_pkg::CMD_CHIP_ERASE;
				3'h6:
				begin
					step_addr = (code_reg == flash_host_pkg::OP_LOCK_TOP) ?
						flash_host_pkg::BOOT_TOP_ADDR : flash_host_pkg::BOOT_BOTTOM_ADDR;
					step_data = flash_host_pkg::LOCK_ANY_DATA;
				end
				default:
				begin
					step_addr = cmd_addr(flash_host_pkg::UNLOCK_ADDR_1);
					step_data = flash_host_pkg::UNLOCK_DATA_1;
				end
			endcase
	end

	wire logic bus_start = (state_reg == S_ISSUE) || (state_reg == S_POLL) ||
		(state_reg == S_FINAL);
	assign cyc.start = bus_start;
	assign cyc.is_write = (state_reg == S_ISSUE);
	assign cyc.addr = (state_reg == S_ISSUE) ? step_addr : addr_reg;
	assign cyc.wdata = step_data;

	// toggle stopped between two reads means the operation ended
	wire logic toggled = first_poll_reg || (cyc.rdata[6] != prev_tog_reg);
	// bit 7 settles to true data for program, one for erase
	wire logic poll_ok = is_erase ? cyc.rdata[7] : (cyc.rdata[7] == data_reg[7]);
	wire logic finished = !toggled && poll_ok;
	wire logic timed_out = (polls_reg >= 32'(POLL_LIMIT));

	assign op_ready = (state_reg == S_IDLE);

	////////////////////////////////////////////////////////////////////
	// sequencer; one command at a time, so none lands during an operation
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			state_reg <= S_IDLE;
			code_reg <= flash_host_pkg::OP_READ;
			addr_reg <= '0;
			data_reg <= '0;
			step_reg <= '0;
			prev_tog_reg <= 1'b0;
			first_poll_reg <= 1'b1;
			polls_reg <= '0;
			err_reg <= 1'b0;
			rdata_reg <= '0;
			op_done <= 1'b0;
			op_error <= 1'b0;
			op_rdata <= '0;
		end
		else
		begin
			op_done <= 1'b0;
			case (state_reg)
				S_IDLE:
					if (op_valid)
					begin
						code_reg <= op_code;
						addr_reg <= op_addr;
						data_reg <= op_data;
						step_reg <= '0;
						err_reg <= 1'b0;
						state_reg <= (op_code == flash_host_pkg::OP_READ) ? S_FINAL : S_ISSUE;
					end
				S_ISSUE:
					state_reg <= S_WAIT;
				S_WAIT:
					if (cyc.done)
					begin
						if (step_reg == last_step || id_exit)
						begin
							// status valid from the last strobe rise
							first_poll_reg <= 1'b1;
							polls_reg <= '0;
							state_reg <= needs_poll ? S_POLL : S_DONE;
						end
						else
						begin
							step_reg <= step_reg + 3'h1;
							state_reg <= S_ISSUE;
						end
					end
				S_POLL:
					state_reg <= S_POLL_WAIT;
				S_POLL_WAIT:
					if (cyc.done)
					begin
						prev_tog_reg <= cyc.rdata[6];
						first_poll_reg <= 1'b0;
						polls_reg <= polls_reg + 32'h1;
						if (finished)
							state_reg <= S_FINAL;
						else if (timed_out)
						begin
							err_reg <= 1'b1;
							state_reg <= S_DONE;
						end
						else
							state_reg <= S_POLL;
					end
				S_FINAL:
					state_reg <= S_FINAL_WAIT;
				S_FINAL_WAIT:
					if (cyc.done)
					begin
						rdata_reg <= cyc.rdata;
						state_reg <= S_DONE;
					end
				S_DONE:
				begin
					op_done <= 1'b1;
					op_error <= err_reg;
					op_rdata <= rdata_reg;
					state_reg <= S_IDLE;
				end
				default:
					state_reg <= S_IDLE;
			endcase
		end
	end

	flash_bus_cycle u_bus
	(
		.ref_clk         (ref_clk),
		.rst             (rst),
		.cyc             (cyc.phy),
		.chip_sel_n      (chip_sel_n),
		.out_gate_n      (out_gate_n),
		.write_strobe_n  (write_strobe_n),
		.flash_addr      (flash_addr),
		.data_lines_o    (data_lines_o),
		.data_lines_oe_n (data_lines_oe_n),
		.data_lines_i    (data_lines_i)
	);
endmodule : flash_erase_and_status_sequencer
`default_nettype wire

/* verilog/flash_host_pkg.sv */
// Functional notes
// - chip erase: six writes ending 5555/10
// - page erase: five prefix writes, then 50
// - poll erase inside the erased page
// - re-read full byte after completion seen
// - program: AA, 55, A0, then address/data
// - lockout: prefix, 5555/70, then boot address
// - id entry 90, exit F0 or single F0
// - write only select low, strobe low, gate high
`default_nettype none
package flash_host_pkg;
	localparam int ADDR_W = 17;
	localparam int DATA_W = 8;
	localparam logic [14:0] UNLOCK_ADDR_1 = 15'h5555;
	localparam logic [14:0] UNLOCK_ADDR_2 = 15'h2AAA;
	localparam logic [7:0] UNLOCK_DATA_1 = 8'hAA;
	localparam logic [7:0] UNLOCK_DATA_2 = 8'h55;
	localparam logic [7:0] CMD_SETUP = 8'h80;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
	localparam logic [7:0] CMD_PAGE_ERASE = 8'h50;
	localparam logic [7:0] CMD_PROGRAM = 8'hA0;
	localparam logic [7:0] CMD_LOCKOUT = 8'h70;
	localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
	localparam logic [7:0] CMD_ID_EXIT = 8'hF0;
	localparam logic [7:0] LOCK_ANY_DATA = 8'h00;
	localparam logic [16:0] BOOT_TOP_ADDR = 17'h1FFFF;
	localparam logic [16:0] BOOT_BOTTOM_ADDR = 17'h00000;
	localparam int PAGE_LSB = 12;
	// bus phase times in ns, rounded up to cycles at 5 ns
	localparam int CLK_NS = 5;
	localparam int WE_LOW_NS = 100;
	localparam int WE_HIGH_NS = 100;
	localparam int SETUP_NS = 40;
	localparam int READ_NS = 90;
	localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int WE_HIGH_CYC = (WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
	localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int READ_CYC = (READ_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W = 8;
	localparam logic [2:0] OP_READ = 3'h0;
	localparam logic [2:0] OP_PROGRAM = 3'h1;
	localparam logic [2:0] OP_CHIP_ERASE = 3'h2;
	localparam logic [2:0] OP_PAGE_ERASE = 3'h3;
	localparam logic [2:0] OP_LOCK_TOP = 3'h4;
	localparam logic [2:0] OP_LOCK_BOTTOM = 3'h5;
	localparam logic [2:0] OP_ID_ENTRY = 3'h6;
	localparam logic [2:0] OP_ID_EXIT = 3'h7;
	localparam int MAX_STEPS = 7;
endpackage : flash_host_pkg
`default_nettype wire
